// ===== rtl/flash_host_consts.vh
// timing counts and field constants for the parallel flash host controller
// assumes a 125 MHz clock, period 8 ns
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH
`define CLK_PERIOD_NS      8
`define T_ACC_NS           70
`define T_ACC_CYC          ((`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WP_NS            35
`define T_WP_CYC           ((`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_SETUP_NS         16
`define T_SETUP_CYC        ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RST_NS           500
`define T_RST_CYC          ((`T_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_READY_NS         500
`define T_READY_CYC        ((`T_READY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_W             18
`define DATA_W             16
`define CNT_W              8
`endif

// ===== rtl/flash_host.v
// host controller driving an asynchronous parallel flash through its pins
// assumes requests from same-clock logic; flash pins are outside the clock domain
// Overview of operation
// - reads drive chip select and output gate low, write strobe high, reset high
// - write strobe stays high for the whole read access
// - command writes drive write strobe and chip select low, output gate high
// - after standby wait the chip-select access time before sampling
`timescale 1ns/100ps
`include "flash_host_consts.vh"
module flash_host #(
  parameter RST_CYC   = `T_RST_CYC,
  parameter READY_CYC = `T_READY_CYC
) (
  // clock and reset
  input  wire                 CLOCK_IN,
  input  wire                 SRST_IN,
  // request side
  input  wire                 REQ_VALID_IN,
  input  wire                 REQ_WRITE_IN,
  input  wire                 BYTE_MODE_IN,
  input  wire [`ADDR_W:0]     REQ_ADDR_IN,
  input  wire [`DATA_W-1:0]   REQ_WDATA_IN,
  input  wire                 FLASH_RESET_REQ_IN,
  output reg                  REQ_READY_OUT,
  output reg                  RDATA_VALID_OUT,
  output reg  [`DATA_W-1:0]   RDATA_OUT,
  output reg                  BUSY_OUT,
  // flash pins
  output reg  [`ADDR_W-1:0]   ADDR_OUT,
  output reg                  CE_N_OUT,
  output reg                  OE_N_OUT,
  output reg                  WE_N_OUT,
  output reg                  RESET_N_OUT,
  output reg                  WORD_MODE_OUT,
  input  wire [`DATA_W-1:0]   DQ_IN,
  output reg  [`DATA_W-1:0]   DQ_OUT,
  output reg  [`DATA_W-1:0]   DQ_OE_N_OUT,
  input  wire                 READY_BUSY_N_IN
);
  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_RD    = 3'd1;
  localparam [2:0] S_WSET  = 3'd2;
  localparam [2:0] S_WPUL  = 3'd3;
  localparam [2:0] S_WHOLD = 3'd4;
  localparam [2:0] S_RST   = 3'd5;
  localparam [2:0] S_RREC  = 3'd6;
  localparam integer      ACC_I  = `T_ACC_CYC;
  localparam integer      WP_I   = `T_WP_CYC;
  localparam integer      SET_I  = `T_SETUP_CYC;
  localparam integer      RST_I  = RST_CYC;
  localparam integer      RDY_I  = READY_CYC;
  // counts cut to the counter width on purpose
  localparam [`CNT_W-1:0] ACC_C  = ACC_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] WP_C   = WP_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] SET_C  = SET_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] RST_C  = RST_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] RDY_C  = RDY_I[`CNT_W-1:0];

  reg  [2:0]          state;
  reg  [`CNT_W-1:0]   cnt;
  reg                 rb_s1;
  reg                 rb_s2;
  reg                 rb_s3;
  reg                 byte_mode;
  reg                 rb_level;
  reg  [`DATA_W-1:0]  dq_s1;
  reg  [`DATA_W-1:0]  dq_s2;
  reg  [`DATA_W-1:0]  dq_s3;
  reg  [`DATA_W-1:0]  dq_level;
  genvar              g;

  // ready/busy synchroniser, change counts once stages two and three agree
  always @(posedge CLOCK_IN)
  begin
    rb_s1 <= READY_BUSY_N_IN;
    rb_s2 <= rb_s1;
    rb_s3 <= rb_s2;
    if (SRST_IN)
      rb_level <= 1'b0;
    else if (rb_s2 == rb_s3)
      rb_level <= rb_s2;
  end

  // data pin synchroniser per bit, same agreement filter
  generate
    for (g = 0; g < `DATA_W; g = g + 1)
    begin : g_dq_sync
      always @(posedge CLOCK_IN)
      begin
        dq_s1[g] <= DQ_IN[g];
        dq_s2[g] <= dq_s1[g];
        dq_s3[g] <= dq_s2[g];
        if (dq_s2[g] == dq_s3[g])
          dq_level[g] <= dq_s2[g];
      end
    end
  endgenerate

  always @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      state           <= S_RST;
      cnt             <= RST_C;
      REQ_READY_OUT   <= 1'b0;
      RDATA_VALID_OUT <= 1'b0;
      RDATA_OUT       <= 16'h0000;
      BUSY_OUT        <= 1'b1;
      ADDR_OUT        <= 18'h0_0000;
      CE_N_OUT        <= 1'b1;
      OE_N_OUT        <= 1'b1;
      WE_N_OUT        <= 1'b1;
      RESET_N_OUT     <= 1'b0;
      WORD_MODE_OUT   <= 1'b1;
      DQ_OUT          <= 16'h0000;
      DQ_OE_N_OUT     <= 16'hFFFF;
      byte_mode       <= 1'b0;
    end
    else
    begin
      RDATA_VALID_OUT <= 1'b0;
      BUSY_OUT        <= (state != S_IDLE) | ~rb_level;
      case (state)
        S_IDLE:
        begin
          // standby between accesses: chip select high, reset high
          CE_N_OUT    <= 1'b1;
          OE_N_OUT    <= 1'b1;
          WE_N_OUT    <= 1'b1;
          DQ_OE_N_OUT <= 16'hFFFF;
          if (FLASH_RESET_REQ_IN)
          begin
            REQ_READY_OUT <= 1'b0;
            RESET_N_OUT   <= 1'b0;
            cnt           <= RST_C;
            state         <= S_RST;
          end
          else if (REQ_VALID_IN && REQ_READY_OUT)
          begin
            REQ_READY_OUT <= 1'b0;
            byte_mode     <= BYTE_MODE_IN;
            WORD_MODE_OUT <= ~BYTE_MODE_IN;
            ADDR_OUT      <= BYTE_MODE_IN ? REQ_ADDR_IN[`ADDR_W:1]
                                          : REQ_ADDR_IN[`ADDR_W-1:0];
            CE_N_OUT      <= 1'b0;
            if (REQ_WRITE_IN)
            begin
              // output gate stays high before strobe falls
              OE_N_OUT <= 1'b1;
              DQ_OUT   <= BYTE_MODE_IN ? {REQ_ADDR_IN[0], 7'h00, REQ_WDATA_IN[7:0]}
                                       : REQ_WDATA_IN;
              DQ_OE_N_OUT <= 16'h0000;
              cnt      <= SET_C;
              state    <= S_WSET;
            end
            else
            begin
              WE_N_OUT <= 1'b1;
              OE_N_OUT <= 1'b0;
              // top pin carries low address bit in byte mode
              DQ_OUT      <= {REQ_ADDR_IN[0], 15'h0000};
              DQ_OE_N_OUT <= BYTE_MODE_IN ? 16'h7FFF : 16'hFFFF;
              // full access time counted from chip select fall
              cnt         <= ACC_C;
              state       <= S_RD;
            end
          end
          else
            REQ_READY_OUT <= 1'b1;
        end
        S_RD:
        begin
          if (cnt == 8'h00)
          begin
            // sample one edge after the count; the four-edge synchroniser lag eats into the access time
            RDATA_OUT       <= byte_mode ? {8'h00, dq_level[7:0]} : dq_level;
            RDATA_VALID_OUT <= 1'b1;
            CE_N_OUT        <= 1'b1;
            OE_N_OUT        <= 1'b1;
            DQ_OE_N_OUT     <= 16'hFFFF;
            state           <= S_IDLE;
          end
          else
            cnt <= cnt - 8'h01;
        end
        S_WSET:
        begin
          if (cnt == 8'h00)
          begin
            WE_N_OUT <= 1'b0;
            cnt      <= WP_C;
            state    <= S_WPUL;
          end
          else
            cnt <= cnt - 8'h01;
        end
        S_WPUL:
        begin
          if (cnt == 8'h00)
          begin
            // rising strobe latches the command cycle
            WE_N_OUT <= 1'b1;
            cnt      <= SET_C;
            state    <= S_WHOLD;
          end
          else
            cnt <= cnt - 8'h01;
        end
        S_WHOLD:
        begin
          if (cnt == 8'h00)
          begin
            CE_N_OUT    <= 1'b1;
            DQ_OE_N_OUT <= 16'hFFFF;
            state       <= S_IDLE;
          end
          else
            cnt <= cnt - 8'h01;
        end
        S_RST:
        begin
          CE_N_OUT    <= 1'b1;
          OE_N_OUT    <= 1'b1;
          WE_N_OUT    <= 1'b1;
          DQ_OE_N_OUT <= 16'hFFFF;
          RESET_N_OUT <= 1'b0;
          if (cnt == 8'h00)
          begin
            RESET_N_OUT <= 1'b1;
            cnt         <= RDY_C;
            state       <= S_RREC;
          end
          else
            cnt <= cnt - 8'h01;
        end
        S_RREC:
        begin
          // device back in array read after recovery
          if (cnt == 8'h00)
            state <= S_IDLE;
          else
            cnt <= cnt - 8'h01;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule

// ===== tb/flash_host_checker.sv
// pin sequencing assertions for the parallel flash host
// assumes binding onto flash_host; sees its ports only
`timescale 1ns/100ps
module flash_host_checker (
  input wire        CLOCK_IN,
  input wire        SRST_IN,
  input wire        REQ_VALID_IN,
  input wire        REQ_WRITE_IN,
  input wire        FLASH_RESET_REQ_IN,
  input wire        REQ_READY_OUT,
  input wire        RDATA_VALID_OUT,
  input wire        CE_N_OUT,
  input wire        OE_N_OUT,
  input wire        WE_N_OUT,
  input wire        RESET_N_OUT,
  input wire        WORD_MODE_OUT,
  input wire [15:0] DQ_OE_N_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);
  a_read_strobes: assert property (!OE_N_OUT |-> !CE_N_OUT && WE_N_OUT && RESET_N_OUT)
    else $error("read strobes wrong");
  a_write_strobes: assert property (!WE_N_OUT |-> !CE_N_OUT && OE_N_OUT)
    else $error("write strobes wrong");
  a_word_drive: assert property (!WE_N_OUT && WORD_MODE_OUT |-> DQ_OE_N_OUT == 16'h0000)
    else $error("word write not driving all pins");
  a_byte_float: assert property (!OE_N_OUT && !WORD_MODE_OUT |-> DQ_OE_N_OUT[14:8] == 7'h7f)
    else $error("byte read drives middle pins");
  a_byte_lsb: assert property (!OE_N_OUT && !WORD_MODE_OUT |-> !DQ_OE_N_OUT[15])
    else $error("low address pin not driven");
  a_read_release: assert property (!OE_N_OUT |-> DQ_OE_N_OUT[7:0] == 8'hff)
    else $error("host drives data during read");
  a_read_latency: assert property (REQ_READY_OUT && REQ_VALID_IN && !REQ_WRITE_IN
    && !FLASH_RESET_REQ_IN |-> ##[11:12] RDATA_VALID_OUT)
    else $error("read answer late");
  a_reset_quiet: assert property (!RESET_N_OUT |-> CE_N_OUT && OE_N_OUT && WE_N_OUT)
    else $error("strobes active in reset");
  a_reset_start: assert property (REQ_READY_OUT && FLASH_RESET_REQ_IN
    |=> ##[0:1] !RESET_N_OUT)
    else $error("reset pulse missing");
endmodule
bind flash_host flash_host_checker i_chk (.*);

// ===== tb/flash_dev_model.sv
// behavioural flash device: small array, reads, word programs, busy pin
// assumes dq resolved outside from host and device enables
`timescale 1ns/100ps
module flash_dev_model (
  input  wire        clk_in,
  input  wire        ce_n_in,
  input  wire        oe_n_in,
  input  wire        we_n_in,
  input  wire        reset_n_in,
  input  wire        word_in,
  input  wire [17:0] addr_in,
  input  wire [15:0] dq_in,
  output reg  [15:0] dq_out,
  output reg  [15:0] dq_en_out,
  output reg         ready_busy_n_out
);
  reg [15:0] mem [0:15];
  reg        we_d = 1'b1;
  reg        tgl = 1'b0;
  reg [3:0]  busy_cnt = 4'h0;
  integer    i;
  wire [15:0] w = mem[addr_in[3:0]];
  wire        rd = !ce_n_in && !oe_n_in && we_n_in && reset_n_in;
  initial for (i = 0; i < 16; i = i + 1) mem[i] = 16'hc3a5 ^ {4{i[3:0]}};
  always @*
  begin
    dq_out = {16{tgl}} ^ 16'h5a5a;
    dq_en_out = rd ? (word_in ? 16'hffff : 16'h00ff) : 16'h0000;
    if (rd)
      dq_out[7:0] = (word_in || !dq_in[15]) ? w[7:0] : w[15:8];
    if (rd && word_in)
      dq_out[15:8] = w[15:8];
    ready_busy_n_out = (busy_cnt == 4'h0);
  end
  always @(posedge clk_in)
  begin
    tgl <= !tgl;
    we_d <= we_n_in;
    if (busy_cnt != 4'h0)
      busy_cnt <= busy_cnt - 4'h1;
    if (!reset_n_in)
      busy_cnt <= 4'h0;
    else if (we_n_in && !we_d && !ce_n_in && word_in)
    begin
      mem[addr_in[3:0]] <= dq_in;
      busy_cnt <= 4'h6;
    end
  end
endmodule

// ===== tb/flash_host_tb_top.sv
// self-checking bench for flash_host against the behavioural device
// assumes 125 MHz clock and small reset counts
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module flash_host_tb_top;
  reg clk = 1'b0, rst = 1'b1, vld = 1'b0, wr = 1'b0, bm = 1'b0, frst = 1'b0;
  reg [18:0] a = 19'h0_0000;
  reg [15:0] d = 16'h0000, sh [0:15], e;
  wire [15:0] rdata, dq_out, dq_oe_n, dev_dq, dev_en, dq;
  wire [17:0] addr;
  wire rdy, rvld, ce_n, oe_n, we_n, rst_n, word, rb_n, busy;
  integer err_total = 0, cmp_count = 0, i, n;
  reg [31:0] r, r2;
  reg [15:0] exp_v;
  logic [15:0] q [$];
  assign dq = (~dq_oe_n & dq_out) | (dq_oe_n & dev_en & dev_dq) | (dq_oe_n & ~dev_en & 16'hffff);
  initial forever #4 clk = !clk;
  flash_host #(.RST_CYC(2), .READY_CYC(2)) i_dut (.CLOCK_IN(clk), .SRST_IN(rst),
    .REQ_VALID_IN(vld), .REQ_WRITE_IN(wr), .BYTE_MODE_IN(bm), .REQ_ADDR_IN(a),
    .REQ_WDATA_IN(d), .FLASH_RESET_REQ_IN(frst), .REQ_READY_OUT(rdy),
    .RDATA_VALID_OUT(rvld), .RDATA_OUT(rdata), .BUSY_OUT(busy), .ADDR_OUT(addr),
    .CE_N_OUT(ce_n), .OE_N_OUT(oe_n), .WE_N_OUT(we_n), .RESET_N_OUT(rst_n),
    .WORD_MODE_OUT(word), .DQ_IN(dq), .DQ_OUT(dq_out), .DQ_OE_N_OUT(dq_oe_n),
    .READY_BUSY_N_IN(rb_n));
  flash_dev_model i_dev (.clk_in(clk), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .reset_n_in(rst_n), .word_in(word), .addr_in(addr), .dq_in(dq), .dq_out(dev_dq),
    .dq_en_out(dev_en), .ready_busy_n_out(rb_n));
  task report_and_stop;
  begin
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task wait_rdy;
  begin
    n = 0;
    while (rdy !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 300)
    begin
      err_total++;
      report_and_stop;
    end
  end
  endtask
  task req(input logic w, input logic b, input logic [18:0] ad, input logic [15:0] dt);
  begin
    wait_rdy;
    wr = w; bm = b; a = ad; d = dt; vld = 1'b1;
    e = sh[b ? ad[4:1] : ad[3:0]];
    if (!w) q.push_back(b ? {8'h00, ad[0] ? e[15:8] : e[7:0]} : e);
    else if (!b) sh[ad[3:0]] = dt;
    @(posedge clk);
    #1 vld = 1'b0;
    `CHK(addr, b ? ad[18:1] : ad[17:0])
    `CHK(word, !b)
    repeat (2) @(posedge clk);
    #1;
  end
  endtask
  always @(posedge clk)
    if (rvld === 1'b1)
    begin
      if (q.size() == 0)
      begin
        err_total++;
        $display("Error t=%0t unexpected read got %h exp %h", $time, rdata, 16'h0000);
      end
      else
      begin
        exp_v = q.pop_front();
        `CHK(rdata, exp_v)
      end
    end
  initial
  begin
    for (i = 0; i < 16; i++)
      sh[i] = 16'hc3a5 ^ {4{i[3:0]}};
    void'($urandom(32'h8106_d5c6));
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    for (i = 0; i < 32; i++)
    begin
      r = $urandom();
      req(1'b0, i[0], r[18:0], 16'h0000);
    end
    for (i = 0; i < 40; i++)
    begin
      r = $urandom();
      r2 = $urandom();
      req(r[19], 1'b0, r[18:0], r2[15:0]);
    end
    // command cycle then data cycle to one word
    req(1'b1, 1'b0, 19'h0_0005, 16'h00a0);
    req(1'b1, 1'b0, 19'h0_0005, 16'h1234);
    wait_rdy;
    // host still reports busy through synchroniser lag after the device has finished programming
    repeat (3) @(posedge clk);
    #1 `CHK(busy, 1'b1)
    repeat (6) @(posedge clk);
    #1 `CHK(busy, 1'b0)
    req(1'b0, 1'b0, 19'h0_0005, 16'h0000);
    wait_rdy;
    frst = 1'b1;
    @(posedge clk); #1 frst = 1'b0;
    for (i = 0; i < 16; i++) req(1'b0, $urandom() % 2, $urandom(), 16'h0000);
    n = 0;
    while (q.size() != 0 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    if (q.size() != 0) err_total++;
    report_and_stop;
  end
endmodule
